/* core/adc_sample_sequencer_control.sv */
// four-sequencer converter control: triggers, arbitration, averaging, fifos, flags
module adc_sample_sequencer_control
    import seq_ctl_pkg::*;
#(
    parameter int FIFO_D = seq_ctl_pkg::FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    // configuration
    input wire logic [seq_ctl_pkg::NUM_SEQ-1:0] seq_enable,
    input wire logic [seq_ctl_pkg::NUM_SEQ*seq_ctl_pkg::SEL_W-1:0] trig_sel,
    input wire logic [seq_ctl_pkg::NUM_SEQ*seq_ctl_pkg::PRIO_W-1:0] seq_prio,
    input wire logic [seq_ctl_pkg::AVG_W-1:0] avg_factor,
    input wire seq_ctl_pkg::step_cfg_s step_cfg [seq_ctl_pkg::NUM_SEQ][seq_ctl_pkg::MAX_STEPS],
    // trigger inputs
    input wire seq_ctl_pkg::trig_src_s trig_src,
    input wire logic [seq_ctl_pkg::NUM_SEQ-1:0] proc_trig,
    // interrupt control and status
    input wire logic [seq_ctl_pkg::NUM_SEQ-1:0] irq_mask,
    input wire logic [seq_ctl_pkg::NUM_SEQ-1:0] irq_clear,
    output logic [seq_ctl_pkg::NUM_SEQ-1:0] irq_raw,
    output logic [seq_ctl_pkg::NUM_SEQ-1:0] irq_masked,
    // error flags
    input wire logic [seq_ctl_pkg::NUM_SEQ-1:0] ovf_clear,
    input wire logic [seq_ctl_pkg::NUM_SEQ-1:0] unf_clear,
    output logic [seq_ctl_pkg::NUM_SEQ-1:0] ovf_flag,
    output logic [seq_ctl_pkg::NUM_SEQ-1:0] unf_flag,
    // result readout
    input wire logic [seq_ctl_pkg::NUM_SEQ-1:0] rd_req,
    output logic [seq_ctl_pkg::NUM_SEQ*seq_ctl_pkg::DATA_W-1:0] rd_data,
    output logic [seq_ctl_pkg::NUM_SEQ-1:0] rd_valid,
    output logic [seq_ctl_pkg::NUM_SEQ*seq_ctl_pkg::CNT_W-1:0] fifo_count,
    // converter side
    output logic conv_start,
    output logic [seq_ctl_pkg::CHAN_W-1:0] conv_chan,
    input wire logic conv_done,
    input wire logic [seq_ctl_pkg::DATA_W-1:0] conv_data,
    output logic busy
);
    logic rst_meta;
    logic rst_n;
    conv_state_e state_reg;
    logic [NUM_SEQ-1:0] pend_reg;
    logic [NUM_SEQ-1:0] trig_hit;
    logic [NUM_SEQ-1:0] run_req;
    logic [1:0] cur_seq_reg;
    logic [STEP_W-1:0] cur_step_reg;
    logic [ACC_W-1:0] acc_reg;
    logic [6:0] samp_cnt_reg;
    logic [6:0] samp_total;
    logic [AVG_W-1:0] avg_lat_reg;
    logic [DATA_W-1:0] avg_result;
    logic grant_ok;
    logic [1:0] grant_seq;
    step_cfg_s cur_cfg;
    logic last_step;
    logic [NUM_SEQ-1:0] push_v;
    logic [NUM_SEQ-1:0] push_rdy;
    logic [NUM_SEQ-1:0] irq_set;
    logic [NUM_SEQ-1:0] src_level;

    initial begin
        if (FIFO_D != FIFO_DEPTH) begin
            $error("fifo depth must stay at the sequencer depth");
        end
    end

    // reset release through two flops
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // per-sequencer trigger decode and pending store
    genvar g;
    generate
        for (g = 0; g < NUM_SEQ; g++) begin : g_seq
            logic [SEL_W-1:0] sel;
            assign sel = trig_sel[g*SEL_W +: SEL_W];
            always_comb begin
                unique case (sel)
                    trig_sel_processor: src_level[g] = proc_trig[g];
                    trig_sel_comparator_a: src_level[g] = trig_src.comp_a;
                    trig_sel_comparator_b: src_level[g] = trig_src.comp_b;
                    trig_sel_comparator_c: src_level[g] = trig_src.comp_c;
                    trig_sel_external: src_level[g] = trig_src.ext_pin;
                    trig_sel_timer: src_level[g] = trig_src.timer;
                    trig_sel_pwm_gen_a: src_level[g] = trig_src.pwm_a;
                    trig_sel_pwm_gen_b: src_level[g] = trig_src.pwm_b;
                    trig_sel_pwm_gen_c: src_level[g] = trig_src.pwm_c;
                    trig_sel_always: src_level[g] = 1'b1;
                    default: src_level[g] = 1'b0;
                endcase
            end
            // disabled sequencers drop their trigger events
            assign trig_hit[g] = src_level[g] && seq_enable[g];
            // an always source stays requested, so it reruns whenever it wins;
            // a stale pending bit of a disabled sequencer must not be served
            assign run_req[g] = (pend_reg[g] || trig_hit[g]) && seq_enable[g];

            // fifo per sequencer; the store stalls while the target is full
            result_fifo #(
                .WIDTH(DATA_W),
                .DEPTH(FIFO_DEPTH),
                .CW(CNT_W)
            ) u_fifo (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .clk_en(clk_en),
                .in_valid(push_v[g]),
                .in_ready(push_rdy[g]),
                .in_data(avg_result),
                .out_valid(rd_valid[g]),
                .out_ready(rd_req[g]),
                .out_data(rd_data[g*DATA_W +: DATA_W]),
                .count(fifo_count[g*CNT_W +: CNT_W])
            );
        end
    endgenerate

    // pending triggers wait for the converter; grant clears own bit
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_reg <= '0;
        end else if (clk_en) begin
            for (int i = 0; i < NUM_SEQ; i++) begin
                if (!seq_enable[i]) begin
                    pend_reg[i] <= 1'b0;
                end else if (state_reg == ST_IDLE && grant_ok && grant_seq == 2'(i)) begin
                    pend_reg[i] <= 1'b0;
                end else if (trig_hit[i]) begin
                    pend_reg[i] <= 1'b1;
                end
            end
        end
    end

    // priority pick; duplicates fall to lowest index, software keeps them distinct
    always_comb begin
        logic [PRIO_W:0] best;
        best = {1'b1, {PRIO_W{1'b0}}};
        grant_ok = 1'b0;
        grant_seq = 2'h0;
        for (int i = NUM_SEQ - 1; i >= 0; i--) begin
            if (run_req[i] && {1'b0, seq_prio[i*PRIO_W +: PRIO_W]} <= best) begin
                best = {1'b0, seq_prio[i*PRIO_W +: PRIO_W]};
                grant_ok = 1'b1;
                grant_seq = 2'(i);
            end
        end
    end

    // step config of the running step
    assign cur_cfg = step_cfg[cur_seq_reg][cur_step_reg];
    // depth limit ends the sequence even without a last flag
    assign last_step = cur_cfg.step_last_flag ||
        (32'(cur_step_reg) == STEP_DEPTH[cur_seq_reg] - 1);
    // samples per result: one when bypassed, else 2**factor
    assign samp_total = (avg_lat_reg == AVG_OFF) ? 7'h01 : 7'(7'h01 << avg_lat_reg);
    assign avg_result = DATA_W'(acc_reg >> avg_lat_reg);
    assign conv_chan = cur_cfg.chan;
    assign busy = (state_reg != ST_IDLE);

    // store handshake toward the selected fifo
    always_comb begin
        push_v = '0;
        if (state_reg == ST_STORE) begin
            push_v[cur_seq_reg] = 1'b1;
        end
    end

    // converter sequencing
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            cur_seq_reg <= 2'h0;
            cur_step_reg <= '0;
            acc_reg <= '0;
            samp_cnt_reg <= 7'h00;
            avg_lat_reg <= AVG_OFF;
            conv_start <= 1'b0;
        end else if (clk_en) begin
            conv_start <= 1'b0;
            unique case (state_reg)
                ST_IDLE: begin
                    if (grant_ok) begin
                        cur_seq_reg <= grant_seq;
                        cur_step_reg <= '0;
                        // factor held per sequence; codes beyond the max clamp
                        avg_lat_reg <= (avg_factor > AVG_MAX) ? AVG_MAX : avg_factor;
                        state_reg <= ST_START;
                    end
                end
                ST_START: begin
                    acc_reg <= '0;
                    samp_cnt_reg <= 7'h00;
                    conv_start <= 1'b1;
                    state_reg <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (conv_done) begin
                        acc_reg <= acc_reg + ACC_W'(conv_data);
                        if (samp_cnt_reg + 7'h01 == samp_total) begin
                            state_reg <= ST_STORE;
                        end else begin
                            samp_cnt_reg <= samp_cnt_reg + 7'h01;
                            conv_start <= 1'b1;
                        end
                    end
                end
                ST_STORE: begin
                    if (push_rdy[cur_seq_reg]) begin
                        if (last_step) begin
                            state_reg <= ST_IDLE;
                        end else begin
                            cur_step_reg <= cur_step_reg + 1'b1;
                            state_reg <= ST_START;
                        end
                    end
                end
            endcase
        end
    end

    // interrupt event on stored step with its interrupt bit
    always_comb begin
        irq_set = '0;
        if (state_reg == ST_STORE && push_rdy[cur_seq_reg] && cur_cfg.step_irq_flag) begin
            irq_set[cur_seq_reg] = 1'b1;
        end
    end

    // raw status, set wins over a clear in the same cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_raw <= '0;
        end else if (clk_en) begin
            irq_raw <= irq_set | (irq_raw & ~irq_clear);
        end
    end

    // masked view; stale events must be cleared by software before unmasking
    assign irq_masked = irq_raw & irq_mask;

    // overflow: trigger while results still wait in that fifo
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ovf_flag <= '0;
        end else if (clk_en) begin
            for (int i = 0; i < NUM_SEQ; i++) begin
                if (trig_hit[i] && !pend_reg[i] && rd_valid[i]) begin
                    ovf_flag[i] <= 1'b1;
                end else if (ovf_clear[i]) begin
                    ovf_flag[i] <= 1'b0;
                end
            end
        end
    end

    // underflow: read of an empty fifo
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            unf_flag <= '0;
        end else if (clk_en) begin
            for (int i = 0; i < NUM_SEQ; i++) begin
                if (rd_req[i] && !rd_valid[i]) begin
                    unf_flag[i] <= 1'b1;
                end else if (unf_clear[i]) begin
                    unf_flag[i] <= 1'b0;
                end
            end
        end
    end
endmodule

/* core/seq_ctl_pkg.sv */
// shared constants and types for the sample sequencer control block
package seq_ctl_pkg;
    localparam int NUM_SEQ = 4;
    localparam int DATA_W = 12;
    localparam int CHAN_W = 3;
    localparam int MAX_STEPS = 8;
    localparam int STEP_W = 3;
    localparam int FIFO_DEPTH = 8;
    localparam int CNT_W = 4;
    localparam int ACC_W = 18;
    localparam int AVG_W = 3;
    localparam int SEL_W = 4;
    localparam int PRIO_W = 2;
    localparam int STEP_DEPTH [NUM_SEQ] = '{8, 4, 4, 1};
    // averaging code: 0 bypass, n gives 2**n samples, 6 is the largest
    localparam logic [AVG_W-1:0] AVG_OFF = 3'h0;
    localparam logic [AVG_W-1:0] AVG_MAX = 3'h6;
    // trigger source selections
    localparam logic [SEL_W-1:0] trig_sel_processor = 4'h0;
    localparam logic [SEL_W-1:0] trig_sel_comparator_a = 4'h1;
    localparam logic [SEL_W-1:0] trig_sel_comparator_b = 4'h2;
    localparam logic [SEL_W-1:0] trig_sel_comparator_c = 4'h3;
    localparam logic [SEL_W-1:0] trig_sel_external = 4'h4;
    localparam logic [SEL_W-1:0] trig_sel_timer = 4'h5;
    localparam logic [SEL_W-1:0] trig_sel_pwm_gen_a = 4'h6;
    localparam logic [SEL_W-1:0] trig_sel_pwm_gen_b = 4'h7;
    localparam logic [SEL_W-1:0] trig_sel_pwm_gen_c = 4'h8;
    localparam logic [SEL_W-1:0] trig_sel_always = 4'hF;

    typedef struct packed {
        logic [CHAN_W-1:0] chan;
        logic step_last_flag;
        logic step_irq_flag;
    } step_cfg_s;

    typedef struct packed {
        logic comp_a;
        logic comp_b;
        logic comp_c;
        logic ext_pin;
        logic timer;
        logic pwm_a;
        logic pwm_b;
        logic pwm_c;
    } trig_src_s;

    typedef struct packed {
        logic [STEP_W-1:0] step;
        logic [DATA_W-1:0] data;
    } result_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_START = 2'b01,
        ST_WAIT = 2'b10,
        ST_STORE = 2'b11
    } conv_state_e;
endpackage

/* core/result_fifo.sv */
// parameterised result fifo with valid/ready on both sides and a fill count
module result_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8,
    parameter int CW = 4
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [CW-1:0] count
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_reg;
    logic [PW-1:0] rd_reg;
    logic [CW-1:0] cnt_reg;
    logic push;
    logic pop;

    initial begin
        if (DEPTH < 2 || (1 << PW) != DEPTH || CW <= PW) begin
            $error("result_fifo: depth must be a power of two and fit the count");
        end
    end

    // handshakes straight from the fill count
    assign in_ready = (cnt_reg != CW'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign push = in_valid && in_ready && clk_en;
    assign pop = out_valid && out_ready && clk_en;
    assign count = cnt_reg;

    // storage array needs no reset; only pointers and count carry control state
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    // pointers and count
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + CW'(push) - CW'(pop);
        end
    end

    // registered head word, refreshed when head moves or a word lands in an empty or emptying fifo
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_data <= '0;
        end else if (clk_en) begin
            if (pop && cnt_reg > CW'(1)) begin
                out_data <= mem[rd_reg + 1'b1];
            end else if (push && (cnt_reg == '0 || (pop && cnt_reg == CW'(1)))) begin
                out_data <= in_data;
            end
        end
    end
endmodule

/* verif/seq_ctl_props.sv */
// port-level property checker for the sample sequencer control block
module seq_ctl_props
    import seq_ctl_pkg::*;
#(
    parameter int FIFO_D = 8
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [NUM_SEQ-1:0] seq_enable,
    input wire logic [NUM_SEQ-1:0] irq_mask,
    input wire logic [NUM_SEQ-1:0] irq_clear,
    input wire logic [NUM_SEQ-1:0] irq_raw,
    input wire logic [NUM_SEQ-1:0] irq_masked,
    input wire logic [NUM_SEQ-1:0] ovf_flag,
    input wire logic [NUM_SEQ-1:0] ovf_clear,
    input wire logic [NUM_SEQ-1:0] unf_flag,
    input wire logic [NUM_SEQ-1:0] unf_clear,
    input wire logic [NUM_SEQ-1:0] rd_req,
    input wire logic [NUM_SEQ-1:0] rd_valid,
    input wire logic [NUM_SEQ*CNT_W-1:0] fifo_count,
    input wire logic conv_start,
    input wire logic busy
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    mask_gate_a: assert property (irq_masked == (irq_raw & irq_mask))
        else $error("masked status differs from raw and mask");
    // clearing while idle cannot race a store, so the bit must drop
    irq_clear_a: assert property ((irq_clear != 4'h0 && !busy) |=>
        (irq_raw & $past(irq_clear)) == 4'h0) else $error("interrupt survived clear");
    irq_hold_a: assert property (1 |=>
        ($past(irq_raw) & ~$past(irq_clear) & ~irq_raw) == 4'h0)
        else $error("interrupt dropped without clear");
    unf_set_a: assert property ((rd_req & ~rd_valid) != 4'h0 |=>
        ((unf_flag & $past(rd_req) & ~$past(rd_valid)) == ($past(rd_req) & ~$past(rd_valid))))
        else $error("empty read did not flag underflow");
    unf_hold_a: assert property (1 |=>
        ($past(unf_flag) & ~$past(unf_clear) & ~unf_flag) == 4'h0)
        else $error("underflow flag dropped without clear");
    ovf_hold_a: assert property (1 |=>
        ($past(ovf_flag) & ~$past(ovf_clear) & ~ovf_flag) == 4'h0)
        else $error("overflow flag dropped without clear");
    // with every sequencer off and the converter quiet nothing may start
    idle_quiet_a: assert property ((seq_enable == 4'h0 && !busy) [*3] |=> !busy && !conv_start)
        else $error("conversion started with all sequencers off");
    start_pulse_a: assert property (conv_start |-> busy ##1 !conv_start)
        else $error("conversion start not a single busy pulse");

    for (genvar i = 0; i < NUM_SEQ; i++) begin : g_fifo
        fill_valid_a: assert property (rd_valid[i] == (fifo_count[4*i +: 4] != 4'h0))
            else $error("fill count and valid disagree");
        fill_max_a: assert property (fifo_count[4*i +: 4] <= 4'(FIFO_D))
            else $error("fill count beyond depth");
        // no store can land while idle, so a pop alone moves the count
        pop_count_a: assert property (rd_req[i] && rd_valid[i] && !busy |=>
            fifo_count[4*i +: 4] == $past(fifo_count[4*i +: 4]) - 4'h1)
            else $error("pop did not lower the fill count");
    end

    cover property (irq_masked != 4'h0);
    cover property (ovf_flag != 4'h0);
    cover property (unf_flag != 4'h0);
endmodule

/* verif/adc_sample_sequencer_control_bench.sv */
// self-checking bench for the sample sequencer control block
module adc_sample_sequencer_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import seq_ctl_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic clk_en = 1'b1;
    logic [3:0] seq_enable = 4'h0, proc_trig = 4'h0, irq_mask = 4'h0, irq_clear = 4'h0;
    logic [3:0] ovf_clear = 4'h0, unf_clear = 4'h0, rd_req = 4'h0;
    logic [3:0] irq_raw, irq_masked, ovf_flag, unf_flag, rd_valid;
    logic [15:0] trig_sel = 16'h0;
    logic [7:0] seq_prio = 8'hE4;
    logic [2:0] avg_factor = 3'h0;
    step_cfg_s step_cfg [NUM_SEQ][MAX_STEPS];
    trig_src_s trig_src = '0;
    logic [47:0] rd_data;
    logic [15:0] fifo_count;
    logic conv_start, busy, conv_done = 1'b0;
    logic [2:0] conv_chan;
    logic [11:0] conv_data = 12'h0;
    int err_count = 0, num_checks = 0;
    logic [1:0] owner [8];
    logic [11:0] exp_q [4][$];
    logic [1:0] order_q [$];

    adc_sample_sequencer_control #(.FIFO_D(FIFO_DEPTH)) DUT (.ref_clk(ref_clk), .rstn(rstn),
        .clk_en(clk_en), .seq_enable(seq_enable), .trig_sel(trig_sel), .seq_prio(seq_prio),
        .avg_factor(avg_factor), .step_cfg(step_cfg), .trig_src(trig_src),
        .proc_trig(proc_trig), .irq_mask(irq_mask), .irq_clear(irq_clear), .irq_raw(irq_raw),
        .irq_masked(irq_masked), .ovf_clear(ovf_clear), .unf_clear(unf_clear),
        .ovf_flag(ovf_flag), .unf_flag(unf_flag), .rd_req(rd_req), .rd_data(rd_data),
        .rd_valid(rd_valid), .fifo_count(fifo_count), .conv_start(conv_start),
        .conv_chan(conv_chan), .conv_done(conv_done), .conv_data(conv_data), .busy(busy));

    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic ptrig(input logic [3:0] m);
        proc_trig = m;
        tick(1);
        proc_trig = 4'h0;
    endtask

    // quiet for three cycles in a row, since the converter idles briefly between sequences
    task automatic wait_idle();
        int k, q;
        k = 0;
        q = 0;
        while (q < 3 && k < 3000) begin
            tick(1);
            k++;
            q = (busy === 1'b0) ? q + 1 : 0;
        end
        if (q < 3) check(16'h1, 16'h0);
    endtask

    task automatic drain(input int s);
        for (int k = 0; k < 20 && rd_valid[s] === 1'b1; k++) begin
            rd_req[s] = 1'b1;
            tick(1);
            rd_req[s] = 1'b0;
            tick(1);
        end
    endtask

    // n above MAX_STEPS leaves every step without the last mark
    task automatic cfg(input int s, input int n, input int base, input logic irq);
        for (int k = 0; k < MAX_STEPS; k++) begin
            step_cfg[s][k] = '{3'(base + k), k == n - 1, irq};
            if (k < n) owner[3'(base + k)] = 2'(s);
        end
    endtask

    // converter stand-in; keeps the running sum so each stored word can be predicted
    initial begin : conv_model
        int n, lat;
        logic [17:0] acc;
        logic [2:0] fch;
        n = 0;
        acc = '0;
        fch = '0;
        forever begin
            @(negedge ref_clk);
            conv_done = 1'b0;
            conv_data = ~conv_data;
            if (conv_start === 1'b1) begin
                if (n == 0) fch = conv_chan;
                check(16'(conv_chan), 16'(fch));
                lat = $urandom_range(3, 1);
                repeat (lat) @(negedge ref_clk);
                conv_data = 12'($urandom);
                conv_done = 1'b1;
                acc += 18'(conv_data);
                n++;
                if (n == (1 << int'(avg_factor))) begin
                    exp_q[owner[fch]].push_back(12'(acc >> avg_factor));
                    order_q.push_back(owner[fch]);
                    n = 0;
                    acc = '0;
                end
            end
        end
    end

    // each pop is compared with the oldest prediction for that fifo
    always @(posedge ref_clk) begin
        for (int i = 0; i < NUM_SEQ; i++) begin
            if ((rd_req[i] & rd_valid[i]) === 1'b1) begin
                if (exp_q[i].size() == 0) begin
                    check(16'(rd_data[12*i +: 12]), 16'hFFFF);
                end else begin
                    check(16'(rd_data[12*i +: 12]), 16'(exp_q[i].pop_front()));
                end
            end
        end
    end

    initial begin
        repeat (30000) @(posedge ref_clk);
        err_count++;
        results();
    end

    initial begin : main
        logic [1:0] pr [4];
        int s, c, p;
        void'($urandom(70798));
        for (s = 0; s < NUM_SEQ; s++) cfg(s, 1, 0, 1'b0);
        tick(5);
        rstn = 1'b1;
        tick(4);
        check(fifo_count, 16'h0);
        // a trigger while the clock enable is low must leave no trace
        clk_en = 1'b0;
        seq_enable = 4'h1;
        ptrig(4'h1);
        clk_en = 1'b1;
        tick(3);
        check(16'({busy, ovf_flag}), 16'h0);
        // every sequencer stops at its depth when no step ends it
        for (s = 0; s < NUM_SEQ; s++) begin
            cfg(s, 9, 0, 1'b0);
            seq_enable = 4'h1 << s;
            ptrig(4'h1 << s);
            wait_idle();
            check(16'(fifo_count[4*s +: 4]), 16'(STEP_DEPTH[s]));
            check(16'(irq_raw), 16'h0);
            drain(s);
        end
        // each stored word averages 2**f conversions
        cfg(0, 2, 3, 1'b0);
        seq_enable = 4'h1;
        for (c = 0; c <= 6; c++) begin
            avg_factor = 3'(c);
            ptrig(4'h1);
            wait_idle();
            check(16'(fifo_count[3:0]), 16'h2);
            drain(0);
        end
        avg_factor = 3'h0;
        // wrong sources, the processor strobe and a disabled sequencer must all be ignored
        cfg(2, 1, 4, 1'b0);
        for (c = 1; c <= 8; c++) begin
            seq_enable = 4'h0;
            trig_sel[11:8] = 4'(c);
            trig_src = 8'h1 << (8 - c);
            tick(1);
            seq_enable = 4'h4;
            trig_src = ~(8'h1 << (8 - c));
            ptrig(4'h4);
            trig_src = '0;
            tick(4);
            check(16'({busy, fifo_count[11:8]}), 16'h0);
            trig_src = 8'h1 << (8 - c);
            tick(1);
            trig_src = '0;
            wait_idle();
            check(16'(fifo_count[11:8]), 16'h1);
            drain(2);
        end
        trig_sel[11:8] = trig_sel_processor;
        // simultaneous triggers are served by priority
        for (s = 0; s < NUM_SEQ; s++) cfg(s, 1, 2 * s, 1'b0);
        repeat (4) begin
            c = $urandom_range(7, 0);
            for (s = 0; s < NUM_SEQ; s++) pr[s] = c[2] ? 2'(c - s) : 2'(c + s);
            seq_enable = 4'h0;
            seq_prio = {pr[3], pr[2], pr[1], pr[0]};
            tick(1);
            seq_enable = 4'hF;
            order_q.delete();
            ptrig(4'hF);
            wait_idle();
            check(16'(order_q.size()), 16'h4);
            for (p = 0; p < order_q.size(); p++) check(16'(pr[order_q[p]]), 16'(p));
            for (s = 0; s < NUM_SEQ; s++) drain(s);
        end
        // a free-running lowest sequencer still yields to a triggered one
        seq_enable = 4'h0;
        seq_prio = 8'hE4;
        trig_sel[15:12] = trig_sel_always;
        rd_req[3] = 1'b1;
        tick(1);
        seq_enable = 4'h9;
        tick(40);
        ptrig(4'h1);
        tick(20);
        seq_enable = 4'h1;
        wait_idle();
        rd_req[3] = 1'b0;
        check(16'(fifo_count[3:0]), 16'h1);
        check(16'(unf_flag), 16'h8);
        drain(0);
        trig_sel[15:12] = trig_sel_processor;
        // a second trigger before readout flags overflow
        seq_enable = 4'h2;
        ovf_clear = 4'hF;
        unf_clear = 4'hF;
        tick(1);
        ovf_clear = 4'h0;
        unf_clear = 4'h0;
        check(16'({ovf_flag, unf_flag}), 16'h0);
        ptrig(4'h2);
        wait_idle();
        check(16'(ovf_flag), 16'h0);
        ptrig(4'h2);
        wait_idle();
        check(16'(ovf_flag), 16'h2);
        drain(1);
        rd_req[1] = 1'b1;
        tick(1);
        rd_req[1] = 1'b0;
        tick(3);
        check(16'(unf_flag), 16'h2);
        // step interrupt: raw and masked views, clear, then unmask
        cfg(2, 1, 4, 1'b1);
        seq_enable = 4'h4;
        ptrig(4'h4);
        wait_idle();
        check(16'({irq_raw, irq_masked}), 16'h40);
        irq_clear = 4'h4;
        tick(1);
        irq_clear = 4'h0;
        tick(5);
        check(16'(irq_raw), 16'h0);
        irq_mask = 4'h4;
        ptrig(4'h4);
        wait_idle();
        check(16'({irq_raw, irq_masked}), 16'h44);
        drain(2);
        for (s = 0; s < NUM_SEQ; s++) check(16'(exp_q[s].size()), 16'h0);
        results();
    end
endmodule

bind adc_sample_sequencer_control seq_ctl_props #(.FIFO_D(FIFO_D)) chk (.ref_clk(ref_clk),
    .rstn(rstn), .seq_enable(seq_enable), .irq_mask(irq_mask), .irq_clear(irq_clear),
    .irq_raw(irq_raw), .irq_masked(irq_masked), .ovf_flag(ovf_flag), .ovf_clear(ovf_clear),
    .unf_flag(unf_flag), .unf_clear(unf_clear), .rd_req(rd_req), .rd_valid(rd_valid),
    .fifo_count(fifo_count), .conv_start(conv_start), .busy(busy));
